// ### dcss_pkg.sv
/*
 * Constants of the DMA channel service sequencer: register offsets, field
 * positions, reset values and mode encodings.
 * Assumes a word-indexed register port; the sequencer and the test use dcss_pkg::name.
 */
package dcss_pkg;
    localparam int          DCSS_NCH       = 4;
    localparam int          DCSS_AW        = 24;
    localparam int          DCSS_CW        = 16;
    localparam int          DCSS_RA_W      = 5;
    localparam int          DCSS_RD_W      = 24;
    // Register offsets (word index)
    localparam logic [4:0]  DCSS_OFF_CTRL  = 5'h00;
    localparam logic [4:0]  DCSS_OFF_REQ   = 5'h01;
    localparam logic [4:0]  DCSS_OFF_MASK  = 5'h02;
    localparam logic [4:0]  DCSS_OFF_STAT  = 5'h03;
    localparam logic [4:0]  DCSS_OFF_MODE  = 5'h04;
    localparam logic [4:0]  DCSS_OFF_ADDR  = 5'h08;
    localparam logic [4:0]  DCSS_OFF_CNT   = 5'h0C;
    // Device control bits
    localparam int          DCSS_CTL_M2M   = 0;
    localparam int          DCSS_CTL_HOLD  = 1;
    localparam int          DCSS_CTL_COMP  = 2;
    localparam int          DCSS_CTL_BUS16 = 3;
    localparam int          DCSS_CTL_W     = 4;
    localparam logic [3:0]  DCSS_CTL_RST   = 4'h0;
    // Mode fields
    localparam int          DCSS_MD_XLSB   = 0;
    localparam int          DCSS_MD_WORD   = 2;
    localparam int          DCSS_MD_DEC    = 3;
    localparam int          DCSS_MD_W      = 4;
    localparam logic [3:0]  DCSS_MD_RST    = 4'h0;
    localparam logic [1:0]  DCSS_X_SINGLE  = 2'h0;
    localparam logic [1:0]  DCSS_X_DEMAND  = 2'h1;
    localparam logic [1:0]  DCSS_X_BLOCK   = 2'h2;
    localparam logic [1:0]  DCSS_X_CASC    = 2'h3;
    localparam logic [3:0]  DCSS_MASK_RST  = 4'hF;
    localparam logic [3:0]  DCSS_REQ_RST   = 4'h0;
    // Address stepping and upper-address boundary
    localparam logic [23:0] DCSS_STEP_BYTE = 24'h000001;
    localparam logic [23:0] DCSS_STEP_WORD = 24'h000002;
    localparam int          DCSS_LATCH_LSB = 8;
    localparam logic [15:0] DCSS_CNT_LAST  = 16'h0000;
    localparam logic [15:0] DCSS_CNT_STEP  = 16'h0001;
    localparam logic [1:0]  DCSS_CH_M2M_DST = 2'h1;
    localparam logic [1:0]  DCSS_CH_M2M_SRC = 2'h0;

    typedef enum logic [6:0] {
        DCSS_IDLE  = 7'h01,
        DCSS_ARB   = 7'h02,
        DCSS_LATCH = 7'h04,
        DCSS_S2    = 7'h08,
        DCSS_S3    = 7'h10,
        DCSS_S4    = 7'h20,
        DCSS_CASC  = 7'h40
    } dcss_state_t;
endpackage

// ### dcss_sequencer.sv
/*
 * DMA channel service sequencer: four channels, bus hold/release policy,
 * single/demand/block/cascade modes, memory-to-memory, byte/word stepping,
 * compressed timing and software requests.
 * Assumes all inputs synchronous to clk; the processor answers
 * bus_hold_request with bus_hold_grant; end_n is sampled in the last state.
 */
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module dcss_sequencer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [23:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [23:0] reg_rdata,
    input  wire logic [3:0]  channel_request_pin,
    input  wire logic        end_n,
    input  wire logic        bus_hold_grant,
    output logic             bus_hold_request,
    output logic      [3:0]  channel_ack,
    output logic      [23:0] addr_out,
    output logic             upper_byte_enable_n,
    output logic             count_expiry_pulse_n,
    output logic             upper_address_latch_state,
    output logic             xfer_strobe,
    output logic             m2m_write_phase
);
    localparam int NCH = dcss_pkg::DCSS_NCH;

    dcss_pkg::dcss_state_t state_r, state_nxt;
    logic [3:0]  ctrl_r;
    logic [3:0]  mode_r [NCH];
    logic [23:0] addr_r [NCH];
    logic [15:0] cnt_r  [NCH];
    logic [3:0]  swreq_r, mask_r, pend_r, tcflag_r;
    logic [1:0]  svc_ch_r, excl_ch_r, next_ch;
    logic        excl_v_r, m2m_r, phase_r, rel_wait_r;
    logic [23:0] rdata_r, addr_out_r;
    logic        ube_n_r, tc_pulse_n_r;

    // Priority encoder, channel 0 highest
    function automatic logic [1:0] dcss_first(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    logic [3:0]  eff_req, cand, higher;
    logic [1:0]  act_ch, xmode;
    logic        hold_pol, word, tc, end_now, term, fin, carry, cyc_end, svc_end;
    logic        grant_lost;
    logic [23:0] al_addr, step, nxt_addr;

    always_comb begin
        eff_req  = (channel_request_pin & ~mask_r) | swreq_r;
        hold_pol = ctrl_r[dcss_pkg::DCSS_CTL_HOLD];
        act_ch   = (m2m_r && phase_r) ? dcss_pkg::DCSS_CH_M2M_DST : svc_ch_r;
        xmode    = mode_r[svc_ch_r][dcss_pkg::DCSS_MD_XLSB +: 2];
        word     = mode_r[act_ch][dcss_pkg::DCSS_MD_WORD] & ctrl_r[dcss_pkg::DCSS_CTL_BUS16];
        al_addr  = word ? {addr_r[act_ch][23:1], 1'b0} : addr_r[act_ch];
        step     = word ? dcss_pkg::DCSS_STEP_WORD : dcss_pkg::DCSS_STEP_BYTE;
        nxt_addr = mode_r[act_ch][dcss_pkg::DCSS_MD_DEC] ? al_addr - step : al_addr + step;
        carry    = nxt_addr[23:dcss_pkg::DCSS_LATCH_LSB] != al_addr[23:dcss_pkg::DCSS_LATCH_LSB];
        tc       = cnt_r[act_ch] == dcss_pkg::DCSS_CNT_LAST;
        end_now  = !end_n;
        cyc_end  = state_r == dcss_pkg::DCSS_S4;
        higher   = 4'h0;
        for (int i = 0; i < NCH; i++) begin
            if (2'(i) < svc_ch_r) begin
                higher[i] = eff_req[i];
            end
        end
        // Memory-to-memory source phase never ends the service
        fin  = (tc || end_now) && !(m2m_r && !phase_r);
        term = 1'b0;
        if (m2m_r) begin
            term = fin;
        end else begin
            unique case (xmode)
                dcss_pkg::DCSS_X_SINGLE: term = 1'b1;
                dcss_pkg::DCSS_X_DEMAND: term = fin || !eff_req[svc_ch_r]
                                             || (swreq_r[svc_ch_r]
                                                 && !channel_request_pin[svc_ch_r])
                                             || (hold_pol && |higher);
                dcss_pkg::DCSS_X_BLOCK:  term = fin;
                dcss_pkg::DCSS_X_CASC:   term = 1'b1;
            endcase
        end
        svc_end = (cyc_end && term)
               || (state_r == dcss_pkg::DCSS_CASC && !eff_req[svc_ch_r]);
        // At cycle end a channel ended by count, end input or single mode sits out one turn
        cand = eff_req;
        if (cyc_end && (fin || (!m2m_r && xmode == dcss_pkg::DCSS_X_SINGLE))) begin
            cand[svc_ch_r] = 1'b0;
        end
        if (state_r == dcss_pkg::DCSS_ARB && excl_v_r) begin
            cand[excl_ch_r] = 1'b0;
        end
        next_ch    = dcss_first(cand);
        grant_lost = !bus_hold_grant && state_r != dcss_pkg::DCSS_IDLE;
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dcss_pkg::DCSS_IDLE: begin
                if (bus_hold_grant && !rel_wait_r && |pend_r) begin
                    state_nxt = dcss_pkg::DCSS_ARB;
                end
            end
            dcss_pkg::DCSS_ARB: begin
                if (!(|cand)) begin
                    state_nxt = dcss_pkg::DCSS_IDLE;
                end else if (mode_r[next_ch][dcss_pkg::DCSS_MD_XLSB +: 2]
                             == dcss_pkg::DCSS_X_CASC) begin
                    state_nxt = dcss_pkg::DCSS_CASC;
                end else begin
                    state_nxt = dcss_pkg::DCSS_LATCH;
                end
            end
            dcss_pkg::DCSS_LATCH: state_nxt = dcss_pkg::DCSS_S2;
            dcss_pkg::DCSS_S2:    state_nxt = dcss_pkg::DCSS_S3;
            dcss_pkg::DCSS_S3:    state_nxt = dcss_pkg::DCSS_S4;
            dcss_pkg::DCSS_S4: begin
                if (!term) begin
                    // Compressed: skip the upper latch unless address crosses bit 8 or the service is memory-to-memory
                    if (ctrl_r[dcss_pkg::DCSS_CTL_COMP] && !m2m_r && !carry) begin
                        state_nxt = dcss_pkg::DCSS_S2;
                    end else begin
                        state_nxt = dcss_pkg::DCSS_LATCH;
                    end
                end else if (hold_pol && xmode != dcss_pkg::DCSS_X_CASC && |cand) begin
                    state_nxt = dcss_pkg::DCSS_ARB;
                end else begin
                    state_nxt = dcss_pkg::DCSS_IDLE;
                end
            end
            dcss_pkg::DCSS_CASC: begin
                if (!eff_req[svc_ch_r]) begin
                    state_nxt = dcss_pkg::DCSS_IDLE;
                end
            end
        endcase
        if (grant_lost) begin
            state_nxt = dcss_pkg::DCSS_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= dcss_pkg::DCSS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Service bookkeeping
    always_ff @(posedge clk) begin
        if (rst) begin
            svc_ch_r   <= 2'h0;
            excl_ch_r  <= 2'h0;
            excl_v_r   <= 1'b0;
            m2m_r      <= 1'b0;
            phase_r    <= 1'b0;
            rel_wait_r <= 1'b0;
        end else begin
            if (state_r == dcss_pkg::DCSS_ARB && |cand) begin
                svc_ch_r <= next_ch;
                m2m_r    <= ctrl_r[dcss_pkg::DCSS_CTL_M2M] && next_ch == dcss_pkg::DCSS_CH_M2M_SRC;
                phase_r  <= 1'b0;
                excl_v_r <= 1'b0;
            end else if (cyc_end && m2m_r) begin
                phase_r <= !phase_r;
            end
            if (cyc_end && term) begin
                excl_ch_r <= svc_ch_r;
                excl_v_r  <= fin || (!m2m_r && xmode == dcss_pkg::DCSS_X_SINGLE);
            end
            if (state_r != dcss_pkg::DCSS_IDLE && state_nxt == dcss_pkg::DCSS_IDLE) begin
                rel_wait_r <= 1'b1;
                excl_v_r   <= 1'b0;
            end else if (!bus_hold_grant) begin
                rel_wait_r <= 1'b0;
            end
        end
    end

    // Pending requests are only resampled while idle
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_r <= 4'h0;
        end else if (state_r == dcss_pkg::DCSS_IDLE) begin
            pend_r <= eff_req;
        end
    end

    // Control and mode registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= dcss_pkg::DCSS_CTL_RST;
            for (int i = 0; i < NCH; i++) begin
                mode_r[i] <= dcss_pkg::DCSS_MD_RST;
            end
        end else if (reg_wr) begin
            if (reg_addr == dcss_pkg::DCSS_OFF_CTRL) begin
                ctrl_r <= reg_wdata[dcss_pkg::DCSS_CTL_W-1:0];
            end
            for (int i = 0; i < NCH; i++) begin
                if (reg_addr == dcss_pkg::DCSS_OFF_MODE + 5'(i)) begin
                    mode_r[i] <= reg_wdata[dcss_pkg::DCSS_MD_W-1:0];
                end
            end
        end
    end

    // Current address and count: software loads, each finished cycle steps
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NCH; i++) begin
                addr_r[i] <= 24'h000000;
                cnt_r[i]  <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (reg_wr && reg_addr == dcss_pkg::DCSS_OFF_ADDR + 5'(i)) begin
                    addr_r[i] <= reg_wdata;
                end
                if (reg_wr && reg_addr == dcss_pkg::DCSS_OFF_CNT + 5'(i)) begin
                    cnt_r[i] <= reg_wdata[15:0];
                end
            end
            if (cyc_end) begin
                addr_r[act_ch] <= nxt_addr;
                cnt_r[act_ch]  <= cnt_r[act_ch] - dcss_pkg::DCSS_CNT_STEP;
            end
        end
    end

    // Software requests: a set in the same cycle as a clear wins
    always_ff @(posedge clk) begin
        if (rst) begin
            swreq_r <= dcss_pkg::DCSS_REQ_RST;
        end else begin
            logic [3:0] v;
            v = swreq_r;
            if (svc_end || (grant_lost && state_r == dcss_pkg::DCSS_CASC)) begin
                if (!hold_pol || xmode == dcss_pkg::DCSS_X_CASC) begin
                    v = 4'h0;
                end else begin
                    v[svc_ch_r] = 1'b0;
                end
            end
            if (reg_wr && reg_addr == dcss_pkg::DCSS_OFF_REQ) begin
                v = v | reg_wdata[3:0];
            end
            swreq_r <= v;
        end
    end

    // Mask: set for the channel whose service ended by count or end input
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_r <= dcss_pkg::DCSS_MASK_RST;
        end else begin
            logic [3:0] m;
            m = mask_r;
            if (reg_wr && reg_addr == dcss_pkg::DCSS_OFF_MASK) begin
                m = reg_wdata[3:0];
            end
            if (cyc_end && term && fin) begin
                m[svc_ch_r] = 1'b1;
            end
            mask_r <= m;
        end
    end

    // Terminal count flags, cleared by a status read; a new count wins
    always_ff @(posedge clk) begin
        if (rst) begin
            tcflag_r <= 4'h0;
        end else begin
            logic [3:0] t;
            t = tcflag_r;
            if (reg_rd && reg_addr == dcss_pkg::DCSS_OFF_STAT) begin
                t = 4'h0;
            end
            if (cyc_end && tc) begin
                t[act_ch] = 1'b1;
            end
            tcflag_r <= t;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 24'h000000;
        end else begin
            rdata_r <= 24'h000000;
            if (reg_rd) begin
                unique case (reg_addr)
                    dcss_pkg::DCSS_OFF_CTRL: rdata_r <= {20'h00000, ctrl_r};
                    dcss_pkg::DCSS_OFF_REQ:  rdata_r <= {20'h00000, swreq_r};
                    dcss_pkg::DCSS_OFF_MASK: rdata_r <= {20'h00000, mask_r};
                    dcss_pkg::DCSS_OFF_STAT: rdata_r <= {16'h0000, tcflag_r, pend_r};
                    default: begin
                        for (int i = 0; i < NCH; i++) begin
                            if (reg_addr == dcss_pkg::DCSS_OFF_MODE + 5'(i)) begin
                                rdata_r <= {20'h00000, mode_r[i]};
                            end
                            if (reg_addr == dcss_pkg::DCSS_OFF_ADDR + 5'(i)) begin
                                rdata_r <= addr_r[i];
                            end
                            if (reg_addr == dcss_pkg::DCSS_OFF_CNT + 5'(i)) begin
                                rdata_r <= {8'h00, cnt_r[i]};
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Bus outputs, registered one clock behind the state they belong to
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_out_r   <= 24'h000000;
            ube_n_r      <= 1'b1;
            tc_pulse_n_r <= 1'b1;
        end else begin
            addr_out_r   <= al_addr;
            // Byte lanes: 8-bit bus keeps enable high
            if (!ctrl_r[dcss_pkg::DCSS_CTL_BUS16]) begin
                ube_n_r <= 1'b1;
            end else if (word) begin
                ube_n_r <= 1'b0;
            end else begin
                ube_n_r <= !al_addr[0];
            end
            tc_pulse_n_r <= !(cyc_end && tc && !(m2m_r && !phase_r));
        end
    end

    always_comb begin
        channel_ack = 4'h0;
        if (state_r == dcss_pkg::DCSS_CASC
            || (!m2m_r && (state_r == dcss_pkg::DCSS_S2 || state_r == dcss_pkg::DCSS_S3
                           || state_r == dcss_pkg::DCSS_S4))) begin
            channel_ack[svc_ch_r] = 1'b1;
        end
    end

    assign bus_hold_request          = (state_r == dcss_pkg::DCSS_IDLE)
                                     ? (|pend_r && !rel_wait_r) : 1'b1;
    assign reg_rdata                 = rdata_r;
    assign addr_out                  = addr_out_r;
    assign upper_byte_enable_n       = ube_n_r;
    assign count_expiry_pulse_n      = tc_pulse_n_r;
    assign upper_address_latch_state = state_r == dcss_pkg::DCSS_LATCH;
    assign xfer_strobe               = state_r == dcss_pkg::DCSS_S3;
    assign m2m_write_phase           = m2m_r && phase_r;
endmodule // dcss_sequencer

// ### dcss_properties.sv
/* Port checker for the DMA channel service sequencer.
   Bound to every dcss_sequencer instance; sees only its top ports. */
`timescale 1ns/1ps
module dcss_properties (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [3:0] channel_ack,
    input wire logic       bus_hold_grant,
    input wire logic       bus_hold_request,
    input wire logic       count_expiry_pulse_n,
    input wire logic       upper_address_latch_state,
    input wire logic       xfer_strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ack_one_hot_a: assert property ($onehot0(channel_ack))
        else $error("more than one channel acknowledged");
    ack_needs_bus_a: assert property (channel_ack != 4'h0 |-> bus_hold_request)
        else $error("acknowledge without bus request");
    grant_to_strobe_a: assert property ($rose(bus_hold_grant) && bus_hold_request |-> ##4 xfer_strobe)
        else $error("first strobe not four clocks after grant");
    latch_to_strobe_a: assert property (upper_address_latch_state |=>
        !upper_address_latch_state ##1 xfer_strobe)
        else $error("latch state not followed by strobe");
    strobe_spacing_a: assert property (xfer_strobe |=> !xfer_strobe [*2])
        else $error("bus cycle shorter than three clocks");
    expiry_single_a: assert property (!count_expiry_pulse_n |=> count_expiry_pulse_n)
        else $error("expiry pulse longer than one clock");
    expiry_after_cycle_a: assert property ($fell(count_expiry_pulse_n) |-> $past(xfer_strobe, 2))
        else $error("expiry pulse without a finished transfer");
    release_holds_a: assert property ($fell(bus_hold_request) && bus_hold_grant |=> !bus_hold_request)
        else $error("bus request raised again before grant dropped");

    cover property (xfer_strobe ##3 xfer_strobe);
    cover property ($fell(count_expiry_pulse_n));
    cover property ($fell(bus_hold_request));
endmodule // dcss_properties

bind dcss_sequencer dcss_properties u_props (.clk, .rst, .channel_ack, .bus_hold_grant,
    .bus_hold_request, .count_expiry_pulse_n, .upper_address_latch_state, .xfer_strobe);

// ### dcss_host_model.sv
/* Processor side of the hold handshake: grants the bus after a delay.
   Assumes the sequencer request is synchronous to clk. */
`timescale 1ns/1ps
module dcss_host_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       bus_hold_request,
    input  wire logic [3:0] grant_dly,
    output logic            bus_hold_grant
);
    logic [3:0] wait_r;

    // Grant follows request after grant_dly+1 clocks, drops one clock after release
    always_ff @(posedge clk) begin
        if (rst || !bus_hold_request) begin
            bus_hold_grant <= 1'b0;
            wait_r         <= 4'h0;
        end else if (wait_r >= grant_dly) begin
            bus_hold_grant <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule // dcss_host_model

// ### dcss_sequencer_test.sv
/* Self-checking bench of the DMA channel service sequencer.
   Assumes dcss_pkg, the host model and the bound checker are compiled first. */
`timescale 1ns/1ps
module dcss_sequencer_test;
    logic        clk;
    logic        rst;
    logic [4:0]  reg_addr;
    logic [23:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [23:0] reg_rdata;
    logic [3:0]  channel_request_pin;
    logic        end_n;
    logic        bus_hold_grant;
    logic        bus_hold_request;
    logic [3:0]  channel_ack;
    logic [23:0] addr_out;
    logic        upper_byte_enable_n;
    logic        count_expiry_pulse_n;
    logic        upper_address_latch_state;
    logic        xfer_strobe;
    logic        m2m_write_phase;
    logic [3:0]  grant_dly;
    logic        g_q;
    logic        s_hb;
    logic [23:0] s_addr;
    int          n_fail, checked, cyc, n_stb, n_lat, n_exp, n_ses, t0, t1, k;

    dcss_sequencer uut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .channel_request_pin, .end_n, .bus_hold_grant, .bus_hold_request, .channel_ack,
        .addr_out, .upper_byte_enable_n, .count_expiry_pulse_n, .upper_address_latch_state,
        .xfer_strobe, .m2m_write_phase);
    dcss_host_model u_host (.clk, .rst, .bus_hold_request, .grant_dly, .bus_hold_grant);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        g_q <= bus_hold_grant;
        if (bus_hold_grant === 1'b1 && g_q === 1'b0) n_ses++;
        if (xfer_strobe === 1'b1) begin
            if (n_stb == 0) t0 = cyc;
            t1 = cyc;
            n_stb++;
            s_addr = addr_out;
            s_hb = upper_byte_enable_n;
        end
        if (upper_address_latch_state === 1'b1) n_lat++;
        if (count_expiry_pulse_n === 1'b0) n_exp++;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string m);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [4:0] a, input logic [23:0] exp, input string m);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp, m);
    endtask

    task automatic clr;
        n_stb = 0;
        n_lat = 0;
        n_exp = 0;
        n_ses = 0;
    endtask

    // Wait for the service to start and the bus to come back
    task automatic settle;
        int i;
        repeat (8) @(posedge clk);
        for (i = 0; i < 400 && (bus_hold_request !== 1'b0 || bus_hold_grant !== 1'b0); i++)
            @(posedge clk);
        if (i == 400) begin
            n_fail++;
            $display("[ERR] %0t bus never released", $time);
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test;
    end

    initial begin
        rst = 1'b1;
        reg_addr = 5'h00;
        reg_wdata = 24'h000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        channel_request_pin = 4'h0;
        end_n = 1'b1;
        grant_dly = 4'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc(dcss_pkg::DCSS_OFF_CTRL, 24'h000000, "ctrl reset");
        rdc(dcss_pkg::DCSS_OFF_MASK, 24'h00000F, "mask reset");
        rdc(dcss_pkg::DCSS_OFF_REQ, 24'h000000, "request reset");
        rdc(5'h10, 24'h000000, "unmapped read");
        chk(24'(upper_byte_enable_n), 24'h000001, "lane enable reset");
        $display("test reset finished");
        // Single byte under release policy with count zero
        wr(dcss_pkg::DCSS_OFF_ADDR, 24'h001234);
        wr(dcss_pkg::DCSS_OFF_CNT, 24'h000000);
        wr(dcss_pkg::DCSS_OFF_MASK, 24'h00000E);
        clr;
        channel_request_pin <= 4'h1;
        settle;
        channel_request_pin <= 4'h0;
        chk(24'(n_stb), 24'h000001, "single transfers");
        chk(24'(n_exp), 24'h000001, "expiry pulses");
        chk(24'(s_hb), 24'h000001, "8-bit lane enable");
        rdc(dcss_pkg::DCSS_OFF_ADDR, 24'h001235, "byte step");
        rdc(dcss_pkg::DCSS_OFF_CNT, 24'h00FFFF, "count borrow");
        rdc(dcss_pkg::DCSS_OFF_STAT, 24'h000010, "status after expiry");
        $display("test single finished");
        // Word, decrementing, odd start, 16-bit bus, software request through mask
        wr(dcss_pkg::DCSS_OFF_CTRL, 24'h000008);
        wr(dcss_pkg::DCSS_OFF_MODE + 5'h3, 24'h00000C);
        wr(dcss_pkg::DCSS_OFF_ADDR + 5'h3, 24'h000101);
        wr(dcss_pkg::DCSS_OFF_CNT + 5'h3, 24'h000005);
        clr;
        wr(dcss_pkg::DCSS_OFF_REQ, 24'h000008);
        settle;
        chk(24'(n_stb), 24'h000001, "software single transfers");
        chk(s_addr, 24'h000100, "word address aligned");
        chk(24'(s_hb), 24'h000000, "word lane enable");
        rdc(dcss_pkg::DCSS_OFF_ADDR + 5'h3, 24'h0000FE, "word step down");
        rdc(dcss_pkg::DCSS_OFF_CNT + 5'h3, 24'h000004, "count step");
        rdc(dcss_pkg::DCSS_OFF_REQ, 24'h000000, "software bit cleared");
        // Byte lanes on the 16-bit bus, even and odd address
        for (k = 0; k < 2; k++) begin
            wr(dcss_pkg::DCSS_OFF_ADDR + 5'h2, 24'h000200 + 24'(k));
            clr;
            wr(dcss_pkg::DCSS_OFF_REQ, 24'h000004);
            settle;
            chk(s_addr, 24'h000200 + 24'(k), "byte lane address");
            chk(24'(s_hb), 24'(1 - k), "byte lane enable");
        end
        $display("test lanes finished");
        // Block under release policy; a lower software request is dropped
        wr(dcss_pkg::DCSS_OFF_CTRL, 24'h000000);
        grant_dly <= 4'h5;
        wr(dcss_pkg::DCSS_OFF_MODE, 24'h000002);
        wr(dcss_pkg::DCSS_OFF_ADDR, 24'h000040);
        wr(dcss_pkg::DCSS_OFF_CNT, 24'h000003);
        wr(dcss_pkg::DCSS_OFF_MASK, 24'h00000E);
        clr;
        channel_request_pin <= 4'h1;
        wr(dcss_pkg::DCSS_OFF_REQ, 24'h000002);
        settle;
        channel_request_pin <= 4'h0;
        chk(24'(n_stb), 24'h000004, "block transfers");
        chk(24'(n_ses), 24'h000001, "block grants");
        chk(24'(t1 - t0), 24'h00000C, "normal cycle span");
        rdc(dcss_pkg::DCSS_OFF_REQ, 24'h000000, "request register cleared");
        rdc(dcss_pkg::DCSS_OFF_MASK, 24'h00000F, "ended channel masked");
        $display("test block finished");
        // Hold policy serves both software singles in one grant
        wr(dcss_pkg::DCSS_OFF_CTRL, 24'h000002);
        grant_dly <= 4'h0;
        wr(dcss_pkg::DCSS_OFF_MODE + 5'h3, 24'h000000);
        clr;
        wr(dcss_pkg::DCSS_OFF_REQ, 24'h00000C);
        settle;
        chk(24'(n_stb), 24'h000002, "hold transfers");
        chk(24'(n_ses), 24'h000001, "hold grants");
        rdc(dcss_pkg::DCSS_OFF_REQ, 24'h000000, "both bits served");
        $display("test hold finished");
        // Compressed block crossing the upper-address boundary
        wr(dcss_pkg::DCSS_OFF_CTRL, 24'h000004);
        wr(dcss_pkg::DCSS_OFF_MODE + 5'h1, 24'h000002);
        wr(dcss_pkg::DCSS_OFF_ADDR + 5'h1, 24'h0000FE);
        wr(dcss_pkg::DCSS_OFF_CNT + 5'h1, 24'h000003);
        wr(dcss_pkg::DCSS_OFF_MASK, 24'h00000D);
        clr;
        channel_request_pin <= 4'h2;
        settle;
        channel_request_pin <= 4'h0;
        chk(24'(n_stb), 24'h000004, "compressed transfers");
        chk(24'(n_lat), 24'h000002, "upper latch states");
        chk(24'(t1 - t0), 24'h00000A, "compressed span");
        rdc(dcss_pkg::DCSS_OFF_ADDR + 5'h1, 24'h000102, "compressed step");
        $display("test compressed finished");
        // Demand under release policy ended at once by the end input
        wr(dcss_pkg::DCSS_OFF_MODE + 5'h2, 24'h000001);
        wr(dcss_pkg::DCSS_OFF_MASK, 24'h00000B);
        clr;
        end_n <= 1'b0;
        channel_request_pin <= 4'h4;
        settle;
        channel_request_pin <= 4'h0;
        end_n <= 1'b1;
        chk(24'(n_stb), 24'h000001, "demand end input");
        chk(24'(m2m_write_phase), 24'h000000, "no m2m phase");
        rdc(dcss_pkg::DCSS_OFF_MASK, 24'h00000F, "demand channel masked");
        $display("test demand finished");
        end_of_test;
    end
endmodule // dcss_sequencer_test
